// ===== design/ufp_preload_ctrl.sv
// firmware preload and reset release controller for the usb 3.0 host
// assumes a same-clock register port, a same-clock rom byte reader and instruction ram writer
// the pll lock input is asynchronous and is synchronised here
//
// Notes on behaviour
// - descriptor: rom address low, length high
// - bit 0 marks region descriptor valid
// - bits 7:2 give data-block byte offset
// - fetch rom start address in bits 15:0
// - fetch byte count in bits 31:16
// - instruction ram start address in bits 15:0
// - start rising edge launches the copy
// - complete flag sets when copy finishes
// - complete clears when start is cleared
// - bit 7 reads pll lock status
// - bit 8 holds pll and lfps logic
// - bit 9 holds 125mhz power logic
// - bit 10 holds both host cores
// - sixteen 32-bit configuration data words
// - bit 28 tells processor skip ram fill
`timescale 1ns/100ps
`default_nettype none
`include "ufp_regs.svh"
module ufp_preload_ctrl
  import ufp_pkg::*;
#(
  parameter int NREG = 3,
  parameter int NWORDS = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rack,
  // phy and core holds
  input wire logic phy_pll_locked,
  output logic phy_pll_hold,
  output logic phy_power_logic_hold,
  output logic host_core_hold,
  output logic skip_boot_fill,
  // external rom byte reader
  output logic rom_req,
  output logic [15:0] rom_addr,
  input wire logic rom_rvalid,
  input wire logic [7:0] rom_rdata,
  // instruction ram byte writer
  output logic iram_we,
  output logic [15:0] iram_addr,
  output logic [7:0] iram_wdata,
  input wire logic iram_ready,
  // embedded processor view of the data block
  input wire logic [3:0] cfg_word_sel,
  output logic [31:0] cfg_word
);
  if (NREG < 1 || NREG > 4) begin : g_bad_nreg
    $error("region count must be 1 to 4");
  end
  if (NWORDS != 16) begin : g_bad_words
    $error("data block must hold sixteen words");
  end

  // byte-enable merge under a writable mask
  function automatic ufp_word_t merge(input ufp_word_t old, input ufp_word_t wd, input logic [3:0] be,
                                      input ufp_word_t mask);
    ufp_word_t lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~lanes) | (wd & lanes);
  endfunction : merge

  // register storage
  ufp_word_t ctrl_ff;
  ufp_word_t fetch_ff;
  ufp_word_t iram_base_ff;
  ufp_word_t fwver_ff;
  ufp_word_t desc_ff [NREG];
  ufp_word_t vbase_ff [NREG];
  ufp_word_t data_ff [NWORDS];
  logic [31:0] nxt_rdata;

  // engine state
  ufp_state_e st_ff;
  ufp_state_e nxt_st;
  logic start_prev_ff;
  logic done_ff;
  logic req_out_ff;
  ufp_half_t rom_ptr_ff;
  ufp_half_t rom_left_ff;
  ufp_half_t iram_ptr_ff;
  ufp_half_t wr_left_ff;
  logic lock_s1_ff;
  logic lock_s2_ff;
  logic rom_req_ff;
  ufp_half_t rom_addr_ff;
  logic iram_we_ff;
  ufp_half_t iram_addr_ff;
  logic [7:0] iram_wdata_ff;
  logic [31:0] reg_rdata_ff;
  logic reg_rack_ff;
  logic [31:0] cfg_word_ff;

  // address decode
  wire hit_ctrl;
  wire hit_fetch;
  wire hit_iram;
  wire hit_fwver;
  wire hit_desc;
  wire hit_vbase;
  wire hit_data;
  wire [1:0] reg_idx;
  wire [3:0] word_idx;
  assign hit_ctrl = (reg_addr == `UFP_OFS_CTRL);
  assign hit_fetch = (reg_addr == `UFP_OFS_FETCH);
  assign hit_iram = (reg_addr == `UFP_OFS_IRAM);
  assign hit_fwver = (reg_addr == `UFP_OFS_FWVER);
  assign reg_idx = reg_addr[3:2];
  assign hit_desc = (reg_addr[7:4] == 4'(`UFP_OFS_DESC0 >> 4)) && (reg_addr[1:0] == 2'h0) && (32'(reg_idx) < NREG);
  assign hit_vbase = (reg_addr[7:4] == 4'(`UFP_OFS_VBASE0 >> 4)) && (reg_addr[1:0] == 2'h0) && (32'(reg_idx) < NREG);
  assign hit_data = (reg_addr[7:6] == 2'(`UFP_OFS_DATA0 >> 6)) && (reg_addr[1:0] == 2'h0);
  assign word_idx = reg_addr[5:2];

  // engine control terms
  wire start_bit;
  wire start_rise;
  wire launch;
  wire done_set;
  wire rom_issue;
  wire stage_load;
  wire iram_accept;
  assign start_bit = ctrl_ff[`UFP_BIT_START];
  assign start_rise = start_bit && !start_prev_ff;
  assign launch = (st_ff == UFP_IDLE) && start_rise;
  assign done_set = (st_ff == UFP_BUSY) && (wr_left_ff == 16'h0000);
  assign rom_issue = (st_ff == UFP_BUSY) && !req_out_ff && (rom_left_ff != 16'h0000) && fb.in_ready;
  assign stage_load = !iram_we_ff || iram_ready;
  assign iram_accept = iram_we_ff && iram_ready;

  // byte buffer between rom and instruction ram
  ufp_buf_if #(.W(24)) fb (.clk(clk), .resetn(resetn));
  assign fb.in_valid = rom_rvalid && req_out_ff;
  assign fb.in_data = {iram_ptr_ff, rom_rdata};
  assign fb.out_ready = stage_load;
  ufp_pair_buf #(.W(24)) u_buf (.b(fb.buf_side));

  // control register: holds default set, only writable bits stored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= `UFP_CTRL_RST;
    end else if (reg_wr && hit_ctrl) begin
      ctrl_ff <= merge(ctrl_ff, reg_wdata, reg_be, `UFP_CTRL_WMASK);
    end
  end

  // fetch window, ram base and version holder
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fetch_ff <= `UFP_WORD_RST;
      iram_base_ff <= `UFP_WORD_RST;
      fwver_ff <= `UFP_WORD_RST;
    end else begin
      if (reg_wr && hit_fetch) fetch_ff <= merge(fetch_ff, reg_wdata, reg_be, `UFP_FULL_WMASK);
      if (reg_wr && hit_iram) iram_base_ff <= merge(iram_base_ff, reg_wdata, reg_be, `UFP_HALF_WMASK);
      if (reg_wr && hit_fwver) fwver_ff <= merge(fwver_ff, reg_wdata, reg_be, `UFP_HALF_WMASK);
    end
  end

  // region descriptors and validity/base registers
  for (genvar r = 0; r < NREG; r++) begin : g_region
    wire sel_r;
    assign sel_r = (32'(reg_idx) == r);
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        desc_ff[r] <= `UFP_WORD_RST;
        vbase_ff[r] <= `UFP_WORD_RST;
      end else begin
        if (reg_wr && hit_desc && sel_r) desc_ff[r] <= merge(desc_ff[r], reg_wdata, reg_be, `UFP_FULL_WMASK);
        if (reg_wr && hit_vbase && sel_r) vbase_ff[r] <= merge(vbase_ff[r], reg_wdata, reg_be, `UFP_VBASE_WMASK);
      end
    end
  end

  // configuration data words, byte-lane writable
  for (genvar w = 0; w < NWORDS; w++) begin : g_word
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        data_ff[w] <= `UFP_WORD_RST;
      end else if (reg_wr && hit_data && (32'(word_idx) == w)) begin
        data_ff[w] <= merge(data_ff[w], reg_wdata, reg_be, `UFP_FULL_WMASK);
      end
    end
  end

  // read data selection, unmapped reads return zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      nxt_rdata = ctrl_ff;
      nxt_rdata[`UFP_BIT_LOCK] = lock_s2_ff;
      nxt_rdata[`UFP_BIT_DONE] = done_ff;
    end else if (hit_fetch) begin
      nxt_rdata = fetch_ff;
    end else if (hit_iram) begin
      nxt_rdata = iram_base_ff;
    end else if (hit_fwver) begin
      nxt_rdata = fwver_ff;
    end else if (hit_desc) begin
      nxt_rdata = desc_ff[reg_idx];
    end else if (hit_vbase) begin
      nxt_rdata = vbase_ff[reg_idx];
    end else if (hit_data) begin
      nxt_rdata = data_ff[word_idx];
    end
  end

  // registered read answer and processor view
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_ff <= 32'h0000_0000;
      reg_rack_ff <= 1'b0;
      cfg_word_ff <= 32'h0000_0000;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : reg_rdata_ff;
      reg_rack_ff <= reg_rd;
      cfg_word_ff <= data_ff[cfg_word_sel];
    end
  end

  // pll lock synchroniser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
    end else begin
      lock_s1_ff <= phy_pll_locked;
      lock_s2_ff <= lock_s1_ff;
    end
  end

  // engine state machine
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      UFP_IDLE: begin
        if (launch) nxt_st = UFP_BUSY;
      end
      UFP_BUSY: begin
        if (done_set) nxt_st = UFP_DONE;
      end
      UFP_DONE: begin
        if (!start_bit) nxt_st = UFP_IDLE;
      end
      default: nxt_st = UFP_IDLE;
    endcase
  end

  // state, start edge and complete flag; set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= UFP_IDLE;
      start_prev_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      start_prev_ff <= start_bit;
      done_ff <= done_set || (done_ff && start_bit);
    end
  end

  // rom side: one outstanding byte request, only when buffer has room
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rom_ptr_ff <= 16'h0000;
      rom_left_ff <= 16'h0000;
      req_out_ff <= 1'b0;
      rom_req_ff <= 1'b0;
      rom_addr_ff <= 16'h0000;
      iram_ptr_ff <= 16'h0000;
    end else begin
      rom_req_ff <= rom_issue;
      if (launch) begin
        rom_ptr_ff <= fetch_ff[15:0];
        rom_left_ff <= fetch_ff[31:16];
        iram_ptr_ff <= iram_base_ff[15:0];
      end else if (rom_issue) begin
        rom_addr_ff <= rom_ptr_ff;
        rom_ptr_ff <= rom_ptr_ff + 16'h0001;
        rom_left_ff <= rom_left_ff - 16'h0001;
        req_out_ff <= 1'b1;
      end else if (fb.in_valid) begin
        iram_ptr_ff <= iram_ptr_ff + 16'h0001;
        req_out_ff <= 1'b0;
      end
    end
  end

  // ram side: output stage and remaining byte count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      iram_we_ff <= 1'b0;
      iram_addr_ff <= 16'h0000;
      iram_wdata_ff <= 8'h00;
      wr_left_ff <= 16'h0000;
    end else begin
      if (stage_load) begin
        iram_we_ff <= fb.out_valid;
        iram_addr_ff <= fb.out_data[23:8];
        iram_wdata_ff <= fb.out_data[7:0];
      end
      if (launch) wr_left_ff <= fetch_ff[31:16];
      else if (iram_accept) wr_left_ff <= wr_left_ff - 16'h0001;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = reg_rdata_ff;
  assign reg_rack = reg_rack_ff;
  assign phy_pll_hold = ctrl_ff[`UFP_BIT_PLL_HOLD];
  assign phy_power_logic_hold = ctrl_ff[`UFP_BIT_PHY_HOLD];
  assign host_core_hold = ctrl_ff[`UFP_BIT_CORE_HOLD];
  assign skip_boot_fill = ctrl_ff[`UFP_BIT_SKIP];
  assign rom_req = rom_req_ff;
  assign rom_addr = rom_addr_ff;
  assign iram_we = iram_we_ff;
  assign iram_addr = iram_addr_ff;
  assign iram_wdata = iram_wdata_ff;
  assign cfg_word = cfg_word_ff;

  // checks on the engine and the holds
  a_start_launch: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff == UFP_IDLE && start_rise) |=> (st_ff == UFP_BUSY))
    else $error("start edge did not launch the copy");
  a_busy_no_restart: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff != UFP_IDLE && start_rise) |-> !launch ##1 (st_ff != UFP_IDLE))
    else $error("start during copy disturbed the engine");
  a_done_sets: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff == UFP_BUSY && wr_left_ff == 16'h0000) |=> (done_ff && st_ff == UFP_DONE))
    else $error("complete flag not set at end of copy");
  a_done_clears: assert property (@(posedge clk) disable iff (!resetn)
    (done_ff && !start_bit && !done_set) |=> !done_ff ##1 (st_ff == UFP_IDLE || st_ff == UFP_BUSY))
    else $error("complete flag not cleared after start cleared");
  a_lock_view: assert property (@(posedge clk) disable iff (!resetn)
    (reg_rd && hit_ctrl) |=> (reg_rdata[`UFP_BIT_LOCK] == $past(phy_pll_locked, 3)))
    else $error("lock status bit does not follow synchronised lock");
  a_pll_release: assert property (@(posedge clk) disable iff (!resetn)
    (reg_wr && hit_ctrl && reg_be[1]) |=> (phy_pll_hold == $past(reg_wdata[`UFP_BIT_PLL_HOLD])))
    else $error("pll hold does not follow its write");
  a_phy_release: assert property (@(posedge clk) disable iff (!resetn)
    (reg_wr && hit_ctrl && reg_be[1]) |=> (phy_power_logic_hold == $past(reg_wdata[`UFP_BIT_PHY_HOLD])))
    else $error("phy power hold does not follow its write");
  a_core_release: assert property (@(posedge clk) disable iff (!resetn)
    (reg_wr && hit_ctrl && reg_be[1]) |=> (host_core_hold == $past(reg_wdata[`UFP_BIT_CORE_HOLD])))
    else $error("core hold does not follow its write");
  a_rom_start: assert property (@(posedge clk) disable iff (!resetn)
    launch |=> (rom_ptr_ff == $past(fetch_ff[15:0])))
    else $error("rom pointer not loaded from fetch window");
  a_rom_count: assert property (@(posedge clk) disable iff (!resetn)
    launch |=> (rom_left_ff == $past(fetch_ff[31:16]) && wr_left_ff == $past(fetch_ff[31:16])))
    else $error("byte counts not loaded from fetch window");
  a_iram_start: assert property (@(posedge clk) disable iff (!resetn)
    launch |=> (iram_ptr_ff == $past(iram_base_ff[15:0])))
    else $error("ram pointer not loaded from base register");
endmodule : ufp_preload_ctrl
`default_nettype wire

// ===== common/ufp_regs.svh
// register offsets, field positions and reset values of the firmware preload block
// assumes a byte-addressed register port with 32-bit aligned words
`ifndef UFP_REGS_SVH
`define UFP_REGS_SVH

// register offsets (byte addresses)
`define UFP_OFS_CTRL 8'h00
`define UFP_OFS_FETCH 8'h04
`define UFP_OFS_IRAM 8'h08
`define UFP_OFS_DESC0 8'h10
`define UFP_OFS_VBASE0 8'h20
`define UFP_OFS_FWVER 8'h2c
`define UFP_OFS_DATA0 8'h40

// control register field positions
`define UFP_BIT_LOCK 7
`define UFP_BIT_PLL_HOLD 8
`define UFP_BIT_PHY_HOLD 9
`define UFP_BIT_CORE_HOLD 10
`define UFP_BIT_SKIP 28
`define UFP_BIT_START 29
`define UFP_BIT_DONE 30

// validity/base register field positions
`define UFP_BIT_VALID 0
`define UFP_BASE_LSB 2
`define UFP_BASE_MSB 7

// reset values and writable masks
`define UFP_CTRL_RST 32'h0000_0700
`define UFP_CTRL_WMASK 32'h3000_0700
`define UFP_VBASE_WMASK 32'h0000_00fd
`define UFP_HALF_WMASK 32'h0000_ffff
`define UFP_FULL_WMASK 32'hffff_ffff
`define UFP_WORD_RST 32'h0000_0000

`endif

// ===== common/ufp_pkg.sv
// types shared by the firmware preload block
// assumes nothing beyond a SystemVerilog compiler
package ufp_pkg;
  // fetch engine states, one-hot
  typedef enum logic [2:0] {
    UFP_IDLE = 3'b001,
    UFP_BUSY = 3'b010,
    UFP_DONE = 3'b100
  } ufp_state_e;
  typedef logic [15:0] ufp_half_t;
  typedef logic [31:0] ufp_word_t;
endpackage : ufp_pkg

// ===== common/ufp_buf_if.sv
// carrier between the fetch engine and its two-entry byte buffer
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface ufp_buf_if #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic resetn
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  // buffer end
  modport buf_side (input clk, resetn, in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  // engine end
  modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : ufp_buf_if
`default_nettype wire

// ===== design/ufp_pair_buf.sv
// two-entry buffer with valid and ready on both sides
// assumes the carrier interface and a single clock
`timescale 1ns/100ps
`default_nettype none
module ufp_pair_buf
  import ufp_pkg::*;
#(
  parameter int W = 24
) (
  // both sides of the buffer
  ufp_buf_if.buf_side b
);
  if (W < 1) begin : g_bad_width
    $error("buffer width must be at least one bit");
  end

  logic [W-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  wire push;
  wire pop;

  // handshakes and honest full/empty
  assign push = b.in_valid && b.in_ready;
  assign pop = b.out_valid && b.out_ready;
  assign b.in_ready = (cnt_ff != 2'd2);
  assign b.out_valid = (cnt_ff != 2'd0);
  assign b.out_data = mem_ff[rd_ptr_ff];
  assign nxt_cnt = (push && !pop) ? cnt_ff + 2'd1 : ((pop && !push) ? cnt_ff - 2'd1 : cnt_ff);

  // pointers and occupancy
  always_ff @(posedge b.clk or negedge b.resetn) begin
    if (!b.resetn) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'd0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff ^ push;
      rd_ptr_ff <= rd_ptr_ff ^ pop;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge b.clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= b.in_data;
    end
  end
endmodule : ufp_pair_buf
`default_nettype wire

// ===== testbench/ufp_far_model.sv
// far-side model: external rom byte source and instruction ram sink
// assumes the preload block's byte reader and writer ports on the same clock
`timescale 1ns/100ps
`default_nettype none
module ufp_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // stall selection
  input wire logic slow,
  // rom side
  input wire logic rom_req,
  input wire logic [15:0] rom_addr,
  output logic rom_rvalid,
  output logic [7:0] rom_rdata,
  // ram side
  output logic iram_ready
);
  logic pend_ff;
  logic [15:0] addr_ff;
  logic [1:0] wait_ff;
  int seed = 28;
  int r;
  // one byte per request after 0 or 3 cycles; the data line toggles when not valid
  always @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_ff <= 1'b0;
      addr_ff <= 16'h0000;
      wait_ff <= 2'h0;
      rom_rvalid <= 1'b0;
      rom_rdata <= 8'h00;
      iram_ready <= 1'b1;
    end else begin
      r = $random(seed);
      rom_rvalid <= 1'b0;
      rom_rdata <= ~rom_rdata;
      iram_ready <= slow ? r[0] : 1'b1;
      if (rom_req) begin
        pend_ff <= 1'b1;
        addr_ff <= rom_addr;
        wait_ff <= slow ? 2'h3 : 2'h0;
      end else if (pend_ff && wait_ff == 2'h0) begin
        rom_rvalid <= 1'b1;
        rom_rdata <= addr_ff[7:0] ^ addr_ff[15:8] ^ 8'h3c;
        pend_ff <= 1'b0;
      end else if (pend_ff) begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule : ufp_far_model
`default_nettype wire

// ===== testbench/usb3_host_fw_preload_reset_tb.sv
// self-checking bench for the firmware preload and reset release block
// assumes the far-side model and the register offsets header
`timescale 1ns/100ps
`default_nettype none
`include "ufp_regs.svh"
module usb3_host_fw_preload_reset_tb import ufp_pkg::*;;
  logic clk, resetn, reg_wr, reg_rd, reg_rack, phy_pll_locked, slow;
  logic phy_pll_hold, phy_power_logic_hold, host_core_hold, skip_boot_fill;
  logic rom_req, rom_rvalid, iram_we, iram_ready;
  logic [7:0] reg_addr, rom_rdata, iram_wdata;
  logic [3:0] reg_be, cfg_word_sel;
  logic [15:0] rom_addr, iram_addr;
  ufp_word_t reg_wdata, reg_rdata, cfg_word, ctrl_sh, got, d, me, mm;
  ufp_word_t w [16];
  ufp_word_t exp_q [$], msk_q [$];
  logic [23:0] ram_q [$];
  int fail_count, tests_run, seed, done;
  logic [7:0] ofs [10] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h40};
  ufp_word_t wm [10] = '{'1, 32'h0000_ffff, '1, '1, '1, 32'h0000_00fd, 32'h0000_00fd, 32'h0000_00fd,
    32'h0000_ffff, '1};
  logic [7:0] hdr [12] = '{8'h00, 8'h00, 8'h20, 8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};

  ufp_preload_ctrl dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rack(reg_rack),
    .phy_pll_locked(phy_pll_locked), .phy_pll_hold(phy_pll_hold), .phy_power_logic_hold(phy_power_logic_hold),
    .host_core_hold(host_core_hold), .skip_boot_fill(skip_boot_fill), .rom_req(rom_req), .rom_addr(rom_addr),
    .rom_rvalid(rom_rvalid), .rom_rdata(rom_rdata), .iram_we(iram_we), .iram_addr(iram_addr),
    .iram_wdata(iram_wdata), .iram_ready(iram_ready), .cfg_word_sel(cfg_word_sel), .cfg_word(cfg_word));
  ufp_far_model far (.clk(clk), .resetn(resetn), .slow(slow), .rom_req(rom_req), .rom_addr(rom_addr),
    .rom_rvalid(rom_rvalid), .rom_rdata(rom_rdata), .iram_ready(iram_ready));

  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // rom contents seen by the bench
  function automatic logic [7:0] romb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : romb

  task automatic chk(input ufp_word_t g, input ufp_word_t e, input string m);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  // register write, strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input ufp_word_t v);
    @(negedge clk);
    reg_addr = a;
    reg_be = be;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // register read; the note is compared by the monitor, a zero mask only polls
  task automatic rd(input logic [7:0] a, input ufp_word_t e, input ufp_word_t m);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    got = reg_rdata;
  endtask : rd

  // copy one blob from the rom image into the data words
  task automatic put_blob(input int r, input logic [15:0] a, input logic [15:0] n, input logic [5:0] o);
    logic [7:0] b;
    int p;
    wr(`UFP_OFS_DESC0 + 8'(4 * r), 4'hf, {n, a});
    wr(`UFP_OFS_VBASE0 + 8'(4 * r), 4'h1, {24'h0, o, 2'b01});
    for (int i = 0; i < int'(n); i++) begin
      b = romb(16'(a + i));
      p = int'(o) + i;
      wr(`UFP_OFS_DATA0 + 8'(4 * (p / 4)), 4'(1 << (p % 4)), 32'(b) << (8 * (p % 4)));
      w[p / 4][8 * (p % 4) +: 8] = b;
    end
  endtask : put_blob

  // monitor: takes the oldest note whenever a read answer or a ram write appears
  always @(posedge clk) begin
    if (reg_rack === 1'b1) begin
      if (exp_q.size() == 0) chk(0, 1, "unexpected read answer");
      else begin
        me = exp_q.pop_front();
        mm = msk_q.pop_front();
        if (mm != 0) chk(reg_rdata & mm, me & mm, "read data");
      end
    end
    if (iram_we === 1'b1 && iram_ready === 1'b1) begin
      if (ram_q.size() == 0) chk(0, 1, "unexpected ram write");
      else chk(32'({iram_addr, iram_wdata}), 32'(ram_q.pop_front()), "ram write");
    end
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    close_out();
  end

  initial begin
    {resetn, reg_wr, reg_rd, phy_pll_locked, slow} = '0;
    {reg_addr, reg_be, reg_wdata, cfg_word_sel} = '0;
    fail_count = 0;
    tests_run = 0;
    seed = 28;
    repeat (16) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    // reset values and masks of every register except data words 1 to 15
    chk(32'({phy_pll_hold, phy_power_logic_hold, host_core_hold, skip_boot_fill}), 32'h0000_000e, "holds");
    rd(`UFP_OFS_CTRL, `UFP_CTRL_RST, '1);
    for (int i = 0; i < 10; i++) begin
      rd(ofs[i], 0, '1);
      d = $random(seed);
      wr(ofs[i], 4'hf, d);
      rd(ofs[i], d & wm[i], '1);
    end
    // unmapped and misaligned places, read-only control bits
    wr(8'h30, 4'hf, '1);
    rd(8'h30, 0, '1);
    rd(8'h05, 0, '1);
    rd(8'h80, 0, '1);
    ctrl_sh = 32'h1000_0700;
    wr(`UFP_OFS_CTRL, 4'hf, 32'h5000_0780);
    rd(`UFP_OFS_CTRL, ctrl_sh, '1);
    chk(32'(skip_boot_fill), 1, "skip fill");
    // firmware sections into the data words
    for (int k = 0; k < 16; k++) begin
      wr(`UFP_OFS_DATA0 + 8'(4 * k), 4'hf, 0);
      w[k] = 0;
    end
    put_blob(1, {hdr[3], hdr[2]}, {hdr[5], hdr[4]}, 6'h0e);
    put_blob(2, {hdr[11], hdr[10]}, 16'd5, hdr[4][5:0]);
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      cfg_word_sel = 4'(k);
      @(negedge clk);
      chk(cfg_word, w[k], "processor view");
      rd(`UFP_OFS_DATA0 + 8'(4 * k), w[k], '1);
    end
    // copy with a slow far side, restart and window writes ignored while busy
    slow = 1'b1;
    wr(`UFP_OFS_FETCH, 4'hf, {16'd9, 16'h0300});
    wr(`UFP_OFS_IRAM, 4'hf, {16'h0000, 16'h0040});
    for (int k = 0; k < 9; k++) ram_q.push_back({16'(16'h0040 + k), romb(16'(16'h0300 + k))});
    ctrl_sh[29] = 1'b1;
    wr(`UFP_OFS_CTRL, 4'hf, ctrl_sh);
    wr(`UFP_OFS_FETCH, 4'hf, 32'h0001_0000);
    wr(`UFP_OFS_CTRL, 4'hf, ctrl_sh & ~32'h2000_0000);
    wr(`UFP_OFS_CTRL, 4'hf, ctrl_sh);
    done = 0;
    for (int i = 0; i < 500 && done == 0; i++) begin
      rd(`UFP_OFS_CTRL, 0, 0);
      done = (got[30] === 1'b1);
    end
    chk(32'(done), 1, "copy completion");
    chk(32'(ram_q.size()), 0, "bytes left");
    ctrl_sh[29] = 1'b0;
    wr(`UFP_OFS_CTRL, 4'hf, ctrl_sh);
    rd(`UFP_OFS_CTRL, ctrl_sh, '1);
    // zero-length copy completes with no ram write
    wr(`UFP_OFS_FETCH, 4'hf, 0);
    wr(`UFP_OFS_CTRL, 4'hf, ctrl_sh | 32'h2000_0000);
    repeat (4) @(negedge clk);
    rd(`UFP_OFS_CTRL, ctrl_sh | 32'h6000_0000, '1);
    wr(`UFP_OFS_CTRL, 4'hf, ctrl_sh);
    // ordered release of pll, phy and core
    slow = 1'b0;
    ctrl_sh[8] = 1'b0;
    wr(`UFP_OFS_CTRL, 4'hf, ctrl_sh);
    @(negedge clk);
    chk(32'({phy_pll_hold, phy_power_logic_hold, host_core_hold}), 32'h3, "pll hold release");
    phy_pll_locked = 1'b1;
    repeat (4) @(negedge clk);
    rd(`UFP_OFS_CTRL, ctrl_sh | 32'h80, '1);
    ctrl_sh[9] = 1'b0;
    wr(`UFP_OFS_CTRL, 4'hf, ctrl_sh);
    @(negedge clk);
    chk(32'({phy_pll_hold, phy_power_logic_hold, host_core_hold}), 32'h1, "phy hold release");
    ctrl_sh[10] = 1'b0;
    wr(`UFP_OFS_CTRL, 4'h2, ctrl_sh);
    @(negedge clk);
    chk(32'({phy_pll_hold, phy_power_logic_hold, host_core_hold}), 32'h0, "core hold release");
    repeat (4) @(negedge clk);
    chk(32'(exp_q.size()), 0, "answers missing");
    close_out();
  end
endmodule : usb3_host_fw_preload_reset_tb
`default_nettype wire
